// ---- verilog/xirq_params.svh ----
`ifndef XIRQ_PARAMS_SVH
`define XIRQ_PARAMS_SVH
// special function addresses
`define XIRQ_CTRL_ADDR      8'hC0
`define XIRQ_PORT_ADDR      8'hD8
// control register field positions
`define XIRQ_IT2_BIT        3'h0
`define XIRQ_IE2_BIT        3'h1
`define XIRQ_EX2_BIT        3'h2
`define XIRQ_PX2_BIT        3'h3
`define XIRQ_IT3_BIT        3'h4
`define XIRQ_IE3_BIT        3'h5
`define XIRQ_EX3_BIT        3'h6
`define XIRQ_PX3_BIT        3'h7
// standard register field positions
`define XIRQ_TIMER_CTRL_REG_IT0_BIT   3'h0
`define XIRQ_TIMER_CTRL_REG_IT1_BIT   3'h2
// reset values
`define XIRQ_CTRL_RESET     8'h00
`define XIRQ_PORT_RESET     4'hF
// vector addresses in polling order
`define XIRQ_VEC_EXT0       8'h03
`define XIRQ_VEC_TMR0       8'h0B
`define XIRQ_VEC_EXT1       8'h13
`define XIRQ_VEC_TMR1       8'h1B
`define XIRQ_VEC_SER        8'h23
`define XIRQ_VEC_TMR2       8'h2B
`define XIRQ_VEC_EXT2       8'h33
`define XIRQ_VEC_EXT3       8'h3B
`endif

// ---- verilog/xirq_pkg.sv ----
package xirq_pkg;
  // one special function register access from the core
  typedef struct packed {
    logic       wr;     // byte write
    logic       bit_wr; // bit set or clear
    logic [7:0] addr;   // byte or bit address
    logic [7:0] wdata;
    logic       bit_val;
  } sfr_req_t;
  // answer to the core: chosen vector
  typedef struct packed {
    logic       req;
    logic [2:0] src;
    logic [7:0] addr;
    logic       high;
  } vec_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_HIGH = 3'b100
  } svc_state_t;
endpackage

// ---- verilog/xirq_nibble_ctrl.sv ----
`timescale 1ns/100ps
`include "xirq_params.svh"
//Function
//- control register at C0, bit writable
//- source 2 enable at bit address C2
//- priority bit selects high or low level
//- extra sources request only when enabled
//- trigger bit: falling edge else low level
//- edge flag set on edge, cleared on vector
//- source 2 at 33, source 3 at 3B
//- fixed polling order within a level
//- standard enables are enable bits 0..5
//- timer control bits 0,2 select edge
//- nibble port at D8, bit addressable
//- only low four port bits implemented
//- port bits 2,3 feed extra interrupts
//- port pins bidirectional with pull-ups
//- reset: port ones, control zero
module xirq_nibble_ctrl (
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  input  wire xirq_pkg::sfr_req_t i_sfr,
  input  wire logic              i_rd,
  input  wire logic [7:0]        i_irq_enable_reg,
  input  wire logic [7:0]        i_ip_reg,
  input  wire logic [7:0]        i_timer_ctrl_reg,
  input  wire logic [5:0]        i_std_pending,
  input  wire logic              i_vector_ack,
  input  wire logic              i_reti,
  input  wire logic [3:0]        i_nibble_port_in,
  output logic [7:0]             o_rdata,
  output logic                   o_rvalid,
  output xirq_pkg::vec_t         o_vec,
  output logic [3:0]             o_nibble_port_out,
  output logic [3:0]             o_nibble_port_oe,
  output logic                   o_std_edge0_clr,
  output logic                   o_std_edge1_clr
);
  // pin synchroniser
  logic [3:0] pin_s1_ff, pin_s2_ff, pin_prev_ff;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [3:0] port_ff, nxt_port;
  xirq_pkg::svc_state_t state_ff, nxt_state;
  logic       in_high_ff, nxt_in_high;
  xirq_pkg::vec_t vec_ff, nxt_vec;
  logic [7:0] rdata_ff;
  logic       rvalid_ff;
  logic [3:0] oe_ff;

  // decode helper: bit address belongs to byte register
  function automatic logic bit_hit(input logic [7:0] a,
                                   input logic [7:0] base);
    return a[7:3] == base[7:3];
  endfunction

  function automatic logic [7:0] vec_addr(input logic [2:0] s);
    case (s)
      3'h0:    return `XIRQ_VEC_EXT0;
      3'h1:    return `XIRQ_VEC_TMR0;
      3'h2:    return `XIRQ_VEC_EXT1;
      3'h3:    return `XIRQ_VEC_TMR1;
      3'h4:    return `XIRQ_VEC_SER;
      3'h5:    return `XIRQ_VEC_TMR2;
      3'h6:    return `XIRQ_VEC_EXT2;
      default: return `XIRQ_VEC_EXT3;
    endcase
  endfunction

  // poll position compare, shared by the ack and clear decodes
  function automatic logic src_is(input logic [2:0] s,
                                  input logic [2:0] k);
    return s == k;
  endfunction

  // lowest set index wins: position 0 first
  function automatic logic [3:0] pick(input logic [7:0] m);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) r = 4'(i);
    end
    return r;
  endfunction

  // access decode
  wire ctrl_byte_wr = i_sfr.wr && i_sfr.addr == `XIRQ_CTRL_ADDR;
  wire port_byte_wr = i_sfr.wr && i_sfr.addr == `XIRQ_PORT_ADDR;
  wire ctrl_bit_wr  = i_sfr.bit_wr
                      && bit_hit(i_sfr.addr, `XIRQ_CTRL_ADDR);
  wire port_bit_wr  = i_sfr.bit_wr
                      && bit_hit(i_sfr.addr, `XIRQ_PORT_ADDR);
  wire [2:0] bit_idx = i_sfr.addr[2:0];

  // edge and level sources from port bits 2 and 3
  wire pin2 = pin_s2_ff[2];
  wire pin3 = pin_s2_ff[3];
  wire fall2 = pin_prev_ff[2] & ~pin2;
  wire fall3 = pin_prev_ff[3] & ~pin3;
  wire it2 = ctrl_ff[`XIRQ_IT2_BIT];
  wire it3 = ctrl_ff[`XIRQ_IT3_BIT];
  wire ack_now = i_vector_ack && vec_ff.req;
  // an ack only counts while a vector is shown; a stray pulse
  // with no request standing must not clear any flag
  wire ack2 = ack_now && src_is(vec_ff.src, 3'h6);
  wire ack3 = ack_now && src_is(vec_ff.src, 3'h7);

  // control register next value; hardware set beats clear
  // an edge landing in the same cycle as its own ack or a
  // software clear is kept, so no falling edge is ever lost
  // in level mode the flag mirrors the pin and writes are lost
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_byte_wr) nxt_ctrl = i_sfr.wdata;
    if (ctrl_bit_wr) nxt_ctrl[bit_idx] = i_sfr.bit_val;
    if (it2) begin
      if (ack2) nxt_ctrl[`XIRQ_IE2_BIT] = 1'b0;
      if (fall2) nxt_ctrl[`XIRQ_IE2_BIT] = 1'b1;
    end else begin
      nxt_ctrl[`XIRQ_IE2_BIT] = ~pin2;
    end
    if (it3) begin
      if (ack3) nxt_ctrl[`XIRQ_IE3_BIT] = 1'b0;
      if (fall3) nxt_ctrl[`XIRQ_IE3_BIT] = 1'b1;
    end else begin
      nxt_ctrl[`XIRQ_IE3_BIT] = ~pin3;
    end
  end

  // port latch; upper bits are not stored
  // bit writes to positions 4..7 are dropped on purpose, since
  // there are no pins behind them
  always_comb begin
    nxt_port = port_ff;
    if (port_byte_wr) nxt_port = i_sfr.wdata[3:0];
    if (port_bit_wr && !bit_idx[2]) begin
      nxt_port[bit_idx[1:0]] = i_sfr.bit_val;
    end
  end

  // request mask and level split
  wire [7:0] enable_all = {ctrl_ff[`XIRQ_EX3_BIT],
                           ctrl_ff[`XIRQ_EX2_BIT],
                           i_irq_enable_reg[5:0]};
  wire [7:0] pending_all = {ctrl_ff[`XIRQ_IE3_BIT],
                            ctrl_ff[`XIRQ_IE2_BIT], i_std_pending};
  wire [7:0] prio_all = {ctrl_ff[`XIRQ_PX3_BIT],
                         ctrl_ff[`XIRQ_PX2_BIT],
                         i_ip_reg[5:0]};
  // global enable gates every source at once
  wire       global_en = i_irq_enable_reg[7];
  wire [7:0] active = enable_all & pending_all & {8{global_en}};
  wire [3:0] hi_pick = pick(active & prio_all);
  wire [3:0] lo_pick = pick(active & ~prio_all);
  wire       in_svc = state_ff != xirq_pkg::ST_IDLE;
  wire       hi_ok = !hi_pick[3] && state_ff != xirq_pkg::ST_HIGH;
  wire       lo_ok = !lo_pick[3] && state_ff == xirq_pkg::ST_IDLE;

  // vector selection; high level always polled first
  // a shown vector is not replaced by a better one before the
  // ack; the core must ack or the request must fall away first
  // no new vector in the cycle of an ack, so the old source's
  // flag has cleared before it can be polled again
  always_comb begin
    nxt_vec = vec_ff;
    if (ack_now || !vec_ff.req) begin
      nxt_vec.req  = 1'b0;
      if (hi_ok && !ack_now) begin
        nxt_vec.req  = 1'b1;
        nxt_vec.src  = hi_pick[2:0];
        nxt_vec.high = 1'b1;
      end else if (lo_ok && !ack_now) begin
        nxt_vec.req  = 1'b1;
        nxt_vec.src  = lo_pick[2:0];
        nxt_vec.high = 1'b0;
      end
      nxt_vec.addr = vec_addr(nxt_vec.src);
    end else if (!(hi_ok || lo_ok)) begin
      nxt_vec.req = 1'b0; // request withdrawn before ack
    end
  end

  // service level tracker; one level of nesting
  // in_high_ff records a high routine that interrupted a low
  // one, so its return goes back to the low level, not idle
  always_comb begin
    nxt_state   = state_ff;
    nxt_in_high = in_high_ff;
    case (state_ff)
      xirq_pkg::ST_IDLE: begin
        if (ack_now) begin
          nxt_state = vec_ff.high ? xirq_pkg::ST_HIGH : xirq_pkg::ST_LOW;
          nxt_in_high = 1'b0;
        end
      end
      xirq_pkg::ST_LOW: begin
        if (ack_now && vec_ff.high) begin
          nxt_state = xirq_pkg::ST_HIGH;
          nxt_in_high = 1'b1;
        end else if (i_reti) nxt_state = xirq_pkg::ST_IDLE;
      end
      xirq_pkg::ST_HIGH: begin
        if (i_reti) begin
          nxt_state = in_high_ff ? xirq_pkg::ST_LOW : xirq_pkg::ST_IDLE;
          nxt_in_high = 1'b0;
        end
      end
      default: nxt_state = xirq_pkg::ST_IDLE;
    endcase
  end

  // read mux: port reads pins, upper bits read ones
  // pins are read after the synchroniser, so a read shows the
  // level of two cycles back; cheap, and never metastable
  wire rd_ctrl = i_rd && i_sfr.addr == `XIRQ_CTRL_ADDR;
  wire rd_port = i_rd && i_sfr.addr == `XIRQ_PORT_ADDR;
  wire [7:0] nxt_rdata = rd_ctrl ? ctrl_ff
                       : rd_port ? {4'hF, pin_s2_ff} : 8'h00;

  // pull-up style drive: only a zero is driven hard
  wire [3:0] nxt_oe = ~nxt_port;

  // standard external flags clear only in edge mode; a level
  // source keeps its flag until the pin itself goes high
  wire edge0_mode = i_timer_ctrl_reg[`XIRQ_TIMER_CTRL_REG_IT0_BIT];
  wire edge1_mode = i_timer_ctrl_reg[`XIRQ_TIMER_CTRL_REG_IT1_BIT];
  wire nxt_edge0_clr = ack_now && src_is(vec_ff.src, 3'h0) && edge0_mode;
  wire nxt_edge1_clr = ack_now && src_is(vec_ff.src, 3'h2) && edge1_mode;

  // synchroniser and edge history
  // reset to ones, the idle level of a pulled-up pin, so that
  // no false falling edge shows just after reset
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_s1_ff   <= 4'hF;
      pin_s2_ff   <= 4'hF;
      pin_prev_ff <= 4'hF;
    end else begin
      pin_s1_ff   <= i_nibble_port_in;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  // register state
  // enable follows the next latch value, so latch and drive
  // change on the same edge and no glitch reaches the pin
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_ff    <= `XIRQ_CTRL_RESET;
      port_ff    <= `XIRQ_PORT_RESET;
      oe_ff      <= 4'h0;
      state_ff   <= xirq_pkg::ST_IDLE;
      in_high_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      port_ff    <= nxt_port;
      oe_ff      <= nxt_oe;
      state_ff   <= nxt_state;
      in_high_ff <= nxt_in_high;
    end
  end

  // outputs to the core
  // all registered, so the core sees no decode glitches; the
  // price is one cycle of latency on reads and vectors
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      vec_ff          <= '0;
      rdata_ff        <= 8'h00;
      rvalid_ff       <= 1'b0;
      o_std_edge0_clr <= 1'b0;
      o_std_edge1_clr <= 1'b0;
    end else begin
      vec_ff          <= nxt_vec;
      rdata_ff        <= nxt_rdata;
      rvalid_ff       <= rd_ctrl | rd_port;
      o_std_edge0_clr <= nxt_edge0_clr;
      o_std_edge1_clr <= nxt_edge1_clr;
    end
  end

  assign o_vec             = vec_ff;
  assign o_rdata           = rdata_ff;
  assign o_rvalid          = rvalid_ff;
  assign o_nibble_port_out = port_ff;
  assign o_nibble_port_oe  = oe_ff;
  wire unused_ok = in_svc;
endmodule

// ---- sim/xirq_pin_src.sv ----
`timescale 1ns/100ps
// off-chip sources on the nibble pins
module xirq_pin_src (
  input  wire logic [3:0] i_oe,
  input  wire logic [3:0] i_pull_low,
  output logic      [3:0] o_pin
);
  // pull-up unless the port or a source pulls low
  assign o_pin = ~(i_oe | i_pull_low);
endmodule

// ---- sim/xirq_nibble_ctrl_chk.sv ----
`timescale 1ns/100ps
module xirq_nibble_ctrl_chk (
  input wire logic               i_clock,
  input wire logic               i_resetn,
  input wire xirq_pkg::sfr_req_t i_sfr,
  input wire logic               i_rd,
  input wire logic [7:0]         i_irq_enable_reg,
  input wire logic [7:0]         i_ip_reg,
  input wire logic [7:0]         i_timer_ctrl_reg,
  input wire logic [5:0]         i_std_pending,
  input wire logic               i_vector_ack,
  input wire logic               i_reti,
  input wire logic [3:0]         i_nibble_port_in,
  input wire logic [7:0]         o_rdata,
  input wire logic               o_rvalid,
  input wire xirq_pkg::vec_t     o_vec,
  input wire logic [3:0]         o_nibble_port_out,
  input wire logic [3:0]         o_nibble_port_oe,
  input wire logic               o_std_edge0_clr,
  input wire logic               o_std_edge1_clr
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // reads of the two mapped places answer one cycle later
  a_read_answer: assert property (i_rd && (i_sfr.addr == 8'hC0 ||
    i_sfr.addr == 8'hD8) |=> o_rvalid) else $error("read unanswered");
  a_rdata_idle: assert property (!o_rvalid |-> o_rdata == 8'h00)
    else $error("read data without valid");
  a_upper_nibble: assert property (o_rvalid && $past(i_sfr.addr) ==
    8'hD8 |-> o_rdata[7:4] == 4'hF) else $error("upper port bits");
  a_oe_drive_low: assert property (o_nibble_port_oe ==
    ~o_nibble_port_out) else $error("enable not latch inverse");
  a_port_byte_wr: assert property (i_sfr.wr && i_sfr.addr == 8'hD8
    |=> o_nibble_port_out == $past(i_sfr.wdata[3:0]))
    else $error("port byte write");
  a_port_bit_wr: assert property (i_sfr.bit_wr && i_sfr.addr[7:2] ==
    6'h36 |=> o_nibble_port_out[$past(i_sfr.addr[1:0])] ==
    $past(i_sfr.bit_val)) else $error("port bit write");
  a_upper_bit_wr: assert property (i_sfr.bit_wr && i_sfr.addr[7:2] ==
    6'h37 |=> $stable(o_nibble_port_out)) else $error("upper bit write");
  // vector address is eight times the poll position plus three
  a_vector_map: assert property (o_vec.req |->
    o_vec.addr == {o_vec.src, 3'h3}) else $error("vector address");
  a_ack_drops: assert property (i_vector_ack && o_vec.req |=>
    !o_vec.req) else $error("vector kept after ack");
endmodule
bind xirq_nibble_ctrl xirq_nibble_ctrl_chk i_chk (.*);

// ---- sim/extra_ext_irq_and_nibble_port_bench.sv ----
`timescale 1ns/100ps
module extra_ext_irq_and_nibble_port_bench;
  logic               i_clock, i_resetn, i_rd, i_vector_ack, i_reti;
  logic               o_rvalid, o_std_edge0_clr, o_std_edge1_clr;
  logic [7:0]         i_irq_enable_reg, i_ip_reg, i_timer_ctrl_reg, o_rdata;
  logic [5:0]         i_std_pending;
  logic [3:0]         i_nibble_port_in, o_nibble_port_out;
  logic [3:0]         o_nibble_port_oe, src_low;
  xirq_pkg::sfr_req_t i_sfr;
  xirq_pkg::vec_t     o_vec;
  int                 err_count, n_tests, i;
  xirq_nibble_ctrl i_dut (.*);
  xirq_pin_src i_src (.i_oe(o_nibble_port_oe), .i_pull_low(src_low),
    .o_pin(i_nibble_port_in));
  initial begin
    i_clock = 0;
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask
  task automatic cmp(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // b picks bit access, d[0] is the bit value
  task automatic wr(input logic b, input logic [7:0] a, d);
    i_sfr = '{wr: !b, bit_wr: b, addr: a, wdata: d, bit_val: d[0]};
    tick;
    i_sfr = '0;
    tick;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    i_sfr.addr = a;
    i_rd = 1;
    tick;
    i_rd = 0;
    cmp(o_rdata, exp);
    tick;
  endtask
  // bounded wait, since the vector may still show the old source
  task automatic wvec(input logic [7:0] ea, input logic hi);
    for (int k = 0; k < 20 && !(o_vec.req === 1'b1 && o_vec.addr === ea);
      k++) tick;
    cmp({o_vec.req, o_vec.high, o_vec.addr[5:0]}, {1'b1, hi, ea[5:0]});
  endtask
  // ec: expected standard flag clear pulses {edge1, edge0}
  task automatic ack(input logic [7:0] ec = 8'h00);
    i_vector_ack = 1;
    tick;
    i_vector_ack = 0;
    i_std_pending = 6'h00;
    cmp({6'h0, o_std_edge1_clr, o_std_edge0_clr}, ec);
    tick;
  endtask
  task automatic ret;
    i_reti = 1;
    tick;
    i_reti = 0;
    tick;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog, about twenty times the expected run
  initial begin
    #60000;
    err_count++;
    summarize;
  end
  initial begin
    {i_resetn, i_rd, i_vector_ack, i_reti, i_sfr, i_std_pending} = '0;
    {i_irq_enable_reg, i_ip_reg, i_timer_ctrl_reg} = {8'h80, 8'h00, 8'h05};
    {src_low, err_count, n_tests} = '0;
    repeat (3) @(posedge i_clock);
    #1;
    i_resetn = 1;
    repeat (3) tick;
    rd(8'hC0, 8'h00);
    rd(8'hD8, 8'hFF);
    wr(0, 8'hD8, 8'h0A);
    cmp({4'h0, o_nibble_port_out}, 8'h0A);
    wr(1, 8'hD8, 8'h01);
    wr(1, 8'hD9, 8'h00);
    wr(1, 8'hDC, 8'h00);
    rd(8'hD8, 8'hF9);
    rd(8'hC0, 8'h02);
    wr(0, 8'hD8, 8'hFF);
    $display("port test done");
    wr(1, 8'hC2, 8'h01);
    wr(1, 8'hC0, 8'h01);
    rd(8'hC0, 8'h05);
    src_low = 4'h4;
    wvec(8'h33, 0);
    rd(8'hC0, 8'h07);
    src_low = 4'h0;
    ack;
    ret;
    rd(8'hC0, 8'h05);
    wr(1, 8'hC2, 8'h00);
    src_low = 4'h4;
    repeat (6) tick;
    cmp({7'h0, o_vec.req}, 8'h00);
    src_low = 4'h0;
    wr(1, 8'hC2, 8'h01);
    wvec(8'h33, 0);
    ack;
    ret;
    $display("edge test done");
    i_irq_enable_reg = 8'h81;
    i_std_pending = 6'h01;
    wvec(8'h03, 0);
    ack(8'h01);
    wr(1, 8'hC6, 8'h01);
    wr(1, 8'hC7, 8'h01);
    src_low = 4'h8;
    wvec(8'h3B, 1);
    ack;
    rd(8'hC0, 8'hE5);
    src_low = 4'h0;
    ret;
    ret;
    rd(8'hC0, 8'hC5);
    $display("priority test done");
    i_irq_enable_reg = 8'hBF;
    for (i = 0; i < 6; i++) begin
      // a standing vector is kept until withdrawn, so drop it first
      i_std_pending = 6'h00;
      repeat (2) tick;
      i_std_pending = 6'h3F << i;
      wvec(8'(8 * i + 3), 0);
    end
    i_std_pending = 6'h00;
    wr(1, 8'hC7, 8'h00);
    src_low = 4'hC;
    wvec(8'h33, 0);
    ack;
    repeat (6) tick;
    cmp({7'h0, o_vec.req}, 8'h00);
    ret;
    wvec(8'h3B, 0);
    src_low = 4'h0;
    ack;
    ret;
    $display("polling test done");
    summarize;
  end
endmodule
